/* mfid_pkg.sv */
// Constants, function codes, register map and command carrier for the input decoder
package mfid_pkg;

  localparam int NUM_IN = 6;
  localparam int NC_W = 5;

  // Function codes accepted by a terminal selector
  localparam logic [7:0] CODE_MIN = 8'h03;
  localparam logic [7:0] CODE_MAX = 8'h89;
  localparam logic [7:0] FN_STEP0 = 8'h03;
  localparam logic [7:0] FN_STEP1 = 8'h04;
  localparam logic [7:0] FN_STEP2 = 8'h05;
  localparam logic [7:0] FN_HOLD = 8'h0A;
  localparam logic [7:0] FN_UP = 8'h10;
  localparam logic [7:0] FN_DOWN = 8'h11;
  localparam logic [7:0] FN_JOG_FWD = 8'h12;
  localparam logic [7:0] FN_JOG_REV = 8'h13;
  localparam logic [7:0] FN_FAULT_RST = 8'h14;
  localparam logic [7:0] FN_FAST_STOP = 8'h15;
  localparam logic [7:0] FN_PID_OFF = 8'h19;
  localparam logic [7:0] FN_RAMP2 = 8'h1A;
  localparam logic [7:0] FN_PID_ICLR = 8'h30;
  localparam logic [7:0] FN_STEP3 = 8'h32;
  localparam logic [7:0] FN_RUN_FWD = 8'h80;
  localparam logic [7:0] FN_RUN_REV = 8'h81;
  localparam logic [7:0] FN_BASEBLOCK = 8'h82;
  localparam logic [7:0] FN_RUN_SRC = 8'h83;
  localparam logic [7:0] FN_REF_SRC = 8'h84;
  localparam logic [7:0] FN_RIDE = 8'h85;
  localparam logic [7:0] FN_AUTO = 8'h86;
  localparam logic [7:0] FN_CNT_TRIG = 8'h87;
  localparam logic [7:0] FN_CNT_CLR = 8'h88;
  localparam logic [7:0] FN_PULSE = 8'h89;

  // Reference source codes that take preset zero from the stepping speed
  localparam logic [7:0] SRC_KEYPAD_STEP = 8'h00;
  localparam logic [7:0] SRC_TERM_STEP = 8'h06;

  // Selector reset values, terminals one to six
  localparam logic [NUM_IN-1:0][7:0] SEL_RST = {8'h0A, 8'h05, 8'h04, 8'h03, 8'h81, 8'h80};
  localparam logic [31:0] CFG_RST = 32'h0000_0000;

  // Register byte addresses
  localparam logic [31:0] ADDR_SEL0 = 32'h0000_0000;
  localparam logic [31:0] ADDR_CFG = 32'h0000_0018;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_001C;
  localparam logic [31:0] ADDR_COUNT = 32'h0000_0020;
  localparam logic [31:0] ADDR_LEVELS = 32'h0000_0024;

  // Configuration register fields
  localparam int CFG_MASTER_LSB = 0;
  localparam int CFG_AUX_LSB = 8;
  localparam int CFG_NC_LSB = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {STEP_HOLD, STEP_ACCEL, STEP_DECEL} mfid_step_t;

  typedef struct packed {
    logic [3:0] presetIndex;
    logic useSteppingSpeed;
    logic refSourceAux;
    logic runSourceAux;
    logic rampHold;
    mfid_step_t step;
    logic jogFwd;
    logic jogRev;
    logic faultReset;
    logic fastStop;
    logic pidDisable;
    logic rampSet2;
    logic pidIntegralClear;
    logic runFwd;
    logic runRev;
    logic baseblock;
    logic rideThrough;
    logic autoProcess;
    logic pulseIn;
  } mfid_cmd_t;

  localparam int CMD_W = $bits(mfid_cmd_t);

endpackage : mfid_pkg

/* mfid_decoder.sv */
// Multi-function contact input decoder with AXI4-Lite register slave
// Operation
// - Six contact inputs, each passing through its own function selector.
// - Selectors accept codes 0x03 to 0x89 only; others are refused.
// - Terminals three, four, five default to preset index bits 0, 1, 2.
// - Terminal one defaults to forward run.
// - Codes 03, 04, 05, 32 form index bits 0..3; unassigned bits read zero.
// - Index zero keeps reference from the selected master or auxiliary source.
// - Index n from 1 to 15 selects preset speed n.
// - An index bit is one while its function is active, else zero.
// - Preset zero uses stepping speed only for source codes 0 or 6.
// - Code 0A holds the ramp while active.
// - Code 14 resets a fault on the active edge only.
// - Code 1A selects the second ramp time set while active.
// - Code 30 clears the PID integral while active.
// - Code 82 blocks drive output so the motor coasts.
// - Code 83 picks master or auxiliary run command source.
// - Code 84 picks master or auxiliary frequency reference source.
// - Code 85 asserts the ride-through power restore request.
// - Code 87 delivers each rising edge of its inputs ORed together as a counter trigger event, unless code 88 is active.
// - Code 89 pulse input works on terminal six only.
// - Codes 80, 81 run forward or reverse while active, else stop.
// - Code 88 clears the counter and blocks counting while active.
// - A stop command releases an active ramp hold.
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
module mfid_decoder #(
  parameter int COUNT_W = 16
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [mfid_pkg::NUM_IN-1:0] contactIn,
  input wire logic stopRequest,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output mfid_pkg::mfid_cmd_t cmd,
  output logic [COUNT_W-1:0] eventCount
);

  if (COUNT_W < 1 || COUNT_W > 32) begin : g_check
    $error("COUNT_W must lie between 1 and 32");
  end

  localparam int N = mfid_pkg::NUM_IN;

  function automatic logic selHit(input logic [31:0] addr, input int n);
    return addr == mfid_pkg::ADDR_SEL0 + 32'(n * 4);
  endfunction : selHit

  function automatic logic mapped(input logic [31:0] addr);
    return addr <= mfid_pkg::ADDR_LEVELS && addr[1:0] == 2'h0;
  endfunction : mapped

  // True when any terminal holding this code is active
  function automatic logic fnActive(input logic [N-1:0][7:0] sel, input logic [N-1:0] act,
                                    input logic [7:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N; i++) begin
      hit = hit | (act[i] && sel[i] == code);
    end
    return hit;
  endfunction : fnActive

  logic [N-1:0][7:0] sel_reg;
  logic [31:0] cfg_reg;
  logic [N-1:0] sync1_reg, sync2_reg, sync3_reg, level_reg;
  logic [N-1:0] act;
  mfid_pkg::mfid_cmd_t cmd_reg, cmdNext;
  logic [COUNT_W-1:0] count_reg;
  logic holdRelease_reg, faultPrev_reg, trigPrev_reg;
  logic holdAct, faultAct, trigAct, clrAct, upAct, downAct;
  logic [7:0] refSrc;

  logic awHave_reg, wHave_reg, awready_reg, wready_reg, bvalid_reg;
  logic arready_reg, rvalid_reg;
  logic [31:0] awAddr_reg, wData_reg, rdata_reg;
  logic [3:0] wStrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic awTake, wTake, arTake, doWrite;
  logic awHaveNext, wHaveNext, bvalidNext, rvalidNext;

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign cmd = cmd_reg;
  assign eventCount = count_reg;

  // Pin synchroniser; a level change counts once stages two and three agree
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      level_reg <= '0;
    end else begin
      sync1_reg <= contactIn;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      level_reg <= (sync2_reg & sync3_reg) | (level_reg & (sync2_reg | sync3_reg));
    end
  end

  // Break-contact inversion applies to terminals one to five
  assign act = level_reg ^ {1'b0, cfg_reg[mfid_pkg::CFG_NC_LSB +: mfid_pkg::NC_W]};

  // AXI4-Lite write channel: address and data taken in either order
  always_comb begin
    awTake = awvalid && awready_reg;
    wTake = wvalid && wready_reg;
    doWrite = awHave_reg && wHave_reg && !bvalid_reg;
    awHaveNext = (awHave_reg || awTake) && !doWrite;
    wHaveNext = (wHave_reg || wTake) && !doWrite;
    bvalidNext = doWrite || (bvalid_reg && !bready);
    arTake = arvalid && arready_reg;
    rvalidNext = arTake || (rvalid_reg && !rready);
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= mfid_pkg::RESP_OKAY;
      awAddr_reg <= '0;
      wData_reg <= '0;
      wStrb_reg <= '0;
    end else begin
      awHave_reg <= awHaveNext;
      wHave_reg <= wHaveNext;
      awready_reg <= !awHaveNext && !bvalidNext;
      wready_reg <= !wHaveNext && !bvalidNext;
      bvalid_reg <= bvalidNext;
      if (awTake) begin
        awAddr_reg <= awaddr;
      end
      if (wTake) begin
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      if (doWrite) begin
        bresp_reg <= mapped(awAddr_reg) ? mfid_pkg::RESP_OKAY : mfid_pkg::RESP_SLVERR;
      end
    end
  end

  // Selector and configuration storage
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sel_reg <= mfid_pkg::SEL_RST;
      cfg_reg <= mfid_pkg::CFG_RST;
    end else if (doWrite) begin
      for (int i = 0; i < N; i++) begin
        if (selHit(awAddr_reg, i) && wStrb_reg[0] && wData_reg[7:0] >= mfid_pkg::CODE_MIN
            && wData_reg[7:0] <= mfid_pkg::CODE_MAX) begin
          sel_reg[i] <= wData_reg[7:0];
        end
      end
      if (awAddr_reg == mfid_pkg::ADDR_CFG) begin
        for (int b = 0; b < 3; b++) begin
          if (wStrb_reg[b]) begin
            cfg_reg[b*8 +: 8] <= wData_reg[b*8 +: 8];
          end
        end
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= mfid_pkg::RESP_OKAY;
    end else begin
      arready_reg <= !rvalidNext;
      rvalid_reg <= rvalidNext;
      if (arTake) begin
        rresp_reg <= mapped(araddr) ? mfid_pkg::RESP_OKAY : mfid_pkg::RESP_SLVERR;
        rdata_reg <= '0;
        for (int i = 0; i < N; i++) begin
          if (selHit(araddr, i)) begin
            rdata_reg <= {24'h00_0000, sel_reg[i]};
          end
        end
        case (araddr)
          mfid_pkg::ADDR_CFG: rdata_reg <= {8'h00, cfg_reg[23:0] & 24'h1F_FFFF};
          mfid_pkg::ADDR_STATUS: rdata_reg <= 32'(cmd_reg);
          mfid_pkg::ADDR_COUNT: rdata_reg <= 32'(count_reg);
          mfid_pkg::ADDR_LEVELS: rdata_reg <= {26'h000_0000, act};
          default: ;
        endcase
      end
    end
  end

  // Function decode; codes with no table entry match nothing
  always_comb begin
    holdAct = fnActive(sel_reg, act, mfid_pkg::FN_HOLD);
    faultAct = fnActive(sel_reg, act, mfid_pkg::FN_FAULT_RST);
    trigAct = fnActive(sel_reg, act, mfid_pkg::FN_CNT_TRIG);
    clrAct = fnActive(sel_reg, act, mfid_pkg::FN_CNT_CLR);
    upAct = fnActive(sel_reg, act, mfid_pkg::FN_UP);
    downAct = fnActive(sel_reg, act, mfid_pkg::FN_DOWN);
    refSrc = '0;
    cmdNext = '0;
    cmdNext.presetIndex = {fnActive(sel_reg, act, mfid_pkg::FN_STEP3),
                           fnActive(sel_reg, act, mfid_pkg::FN_STEP2),
                           fnActive(sel_reg, act, mfid_pkg::FN_STEP1),
                           fnActive(sel_reg, act, mfid_pkg::FN_STEP0)};
    cmdNext.refSourceAux = fnActive(sel_reg, act, mfid_pkg::FN_REF_SRC);
    cmdNext.runSourceAux = fnActive(sel_reg, act, mfid_pkg::FN_RUN_SRC);
    refSrc = cmdNext.refSourceAux ? cfg_reg[mfid_pkg::CFG_AUX_LSB +: 8]
                                  : cfg_reg[mfid_pkg::CFG_MASTER_LSB +: 8];
    cmdNext.useSteppingSpeed = cmdNext.presetIndex == 4'h0
        && (refSrc == mfid_pkg::SRC_KEYPAD_STEP || refSrc == mfid_pkg::SRC_TERM_STEP);
    cmdNext.rampHold = holdAct && !holdRelease_reg && !stopRequest;
    if (upAct && !downAct) begin
      cmdNext.step = mfid_pkg::STEP_ACCEL;
    end else if (downAct && !upAct) begin
      cmdNext.step = mfid_pkg::STEP_DECEL;
    end else begin
      cmdNext.step = mfid_pkg::STEP_HOLD;
    end
    cmdNext.jogFwd = fnActive(sel_reg, act, mfid_pkg::FN_JOG_FWD);
    cmdNext.jogRev = fnActive(sel_reg, act, mfid_pkg::FN_JOG_REV);
    cmdNext.faultReset = faultAct && !faultPrev_reg;
    cmdNext.fastStop = fnActive(sel_reg, act, mfid_pkg::FN_FAST_STOP);
    cmdNext.pidDisable = fnActive(sel_reg, act, mfid_pkg::FN_PID_OFF);
    cmdNext.rampSet2 = fnActive(sel_reg, act, mfid_pkg::FN_RAMP2);
    cmdNext.pidIntegralClear = fnActive(sel_reg, act, mfid_pkg::FN_PID_ICLR);
    cmdNext.runFwd = fnActive(sel_reg, act, mfid_pkg::FN_RUN_FWD);
    cmdNext.runRev = fnActive(sel_reg, act, mfid_pkg::FN_RUN_REV);
    cmdNext.baseblock = fnActive(sel_reg, act, mfid_pkg::FN_BASEBLOCK);
    cmdNext.rideThrough = fnActive(sel_reg, act, mfid_pkg::FN_RIDE);
    cmdNext.autoProcess = fnActive(sel_reg, act, mfid_pkg::FN_AUTO);
    cmdNext.pulseIn = act[N-1] && sel_reg[N-1] == mfid_pkg::FN_PULSE;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cmd_reg <= '0;
    end else begin
      cmd_reg <= cmdNext;
    end
  end

  // Hold stays released after a stop until the hold input drops
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      holdRelease_reg <= 1'b0;
    end else if (!holdAct) begin
      holdRelease_reg <= 1'b0;
    end else if (stopRequest) begin
      holdRelease_reg <= 1'b1;
    end
  end

  // Event counter: rising trigger edges count, clear input wins and blocks
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      count_reg <= '0;
      trigPrev_reg <= 1'b0;
      faultPrev_reg <= 1'b0;
    end else begin
      trigPrev_reg <= trigAct;
      faultPrev_reg <= faultAct;
      if (clrAct) begin
        count_reg <= '0;
      end else if (trigAct && !trigPrev_reg) begin
        count_reg <= count_reg + COUNT_W'(1);
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_sel_refuse;
    doWrite && (wData_reg[7:0] > mfid_pkg::CODE_MAX || wData_reg[7:0] < mfid_pkg::CODE_MIN)
      |=> $stable(sel_reg);
  endproperty
  a_sel_refuse: assert property (p_sel_refuse) else $error("out of range code stored");

  property p_defaults_index;
    $rose(resetn) |-> sel_reg[2] == mfid_pkg::FN_STEP0 && sel_reg[3] == mfid_pkg::FN_STEP1
      && sel_reg[4] == mfid_pkg::FN_STEP2;
  endproperty
  a_defaults_index: assert property (p_defaults_index) else $error("index defaults wrong");

  property p_default_fwd;
    $rose(resetn) |-> sel_reg[0] == mfid_pkg::FN_RUN_FWD;
  endproperty
  a_default_fwd: assert property (p_default_fwd) else $error("terminal one default wrong");

  property p_fault_edge;
    cmd_reg.faultReset |-> $past(faultPrev_reg) == 1'b0 ##1 !cmd_reg.faultReset;
  endproperty
  a_fault_edge: assert property (p_fault_edge) else $error("fault reset not edge only");

  property p_step_both;
    upAct && downAct |=> cmd_reg.step == mfid_pkg::STEP_HOLD;
  endproperty
  a_step_both: assert property (p_step_both) else $error("both steps did not hold");

  sequence s_clear_held;
    clrAct ##1 clrAct;
  endsequence
  property p_count_clear;
    s_clear_held |=> count_reg == '0;
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("counter not held at zero");

  property p_trigger;
    trigAct && !trigPrev_reg && !clrAct |=> count_reg == $past(count_reg) + 1'b1;
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger edge not counted");

  property p_pulse_six;
    cmd_reg.pulseIn |-> $past(sel_reg[N-1]) == mfid_pkg::FN_PULSE && $past(act[N-1]);
  endproperty
  a_pulse_six: assert property (p_pulse_six) else $error("pulse input from wrong terminal");

  property p_step_zero;
    cmd_reg.useSteppingSpeed |-> cmd_reg.presetIndex == 4'h0;
  endproperty
  a_step_zero: assert property (p_step_zero) else $error("stepping speed with nonzero index");

  sequence s_hold_stop;
    cmd_reg.rampHold ##0 stopRequest;
  endsequence
  property p_hold_release;
    s_hold_stop |=> !cmd_reg.rampHold ##1 (!cmd_reg.rampHold || !$past(holdAct));
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("stop did not release hold");

  property p_bit3_zero;
    !(sel_reg[0] == mfid_pkg::FN_STEP3 || sel_reg[1] == mfid_pkg::FN_STEP3
      || sel_reg[2] == mfid_pkg::FN_STEP3 || sel_reg[3] == mfid_pkg::FN_STEP3
      || sel_reg[4] == mfid_pkg::FN_STEP3 || sel_reg[5] == mfid_pkg::FN_STEP3)
      |=> !cmd_reg.presetIndex[3];
  endproperty
  a_bit3_zero: assert property (p_bit3_zero) else $error("unassigned index bit set");

  property p_baseblock;
    fnActive(sel_reg, act, mfid_pkg::FN_BASEBLOCK) |=> cmd_reg.baseblock;
  endproperty
  a_baseblock: assert property (p_baseblock) else $error("baseblock not asserted");

endmodule : mfid_decoder

/* mfid_contact_model.sv */
// Model of the switches or controller that drive the six contact terminals
`timescale 1ns/1ns
module mfid_contact_model (
  input wire logic mclk,
  input wire logic [mfid_pkg::NUM_IN-1:0] levelReq,
  output logic [mfid_pkg::NUM_IN-1:0] contactIn
);
  // Contacts change just after a clock edge and then hold their level
  always_ff @(posedge mclk) begin
    contactIn <= levelReq;
  end
endmodule : mfid_contact_model

/* tb_top.sv */
// Self-checking testbench for the contact input decoder
`timescale 1ns/1ns
module tb_top;
  logic mclk, resetn, stopRequest, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [5:0] levelReq, contactIn;
  logic [15:0] eventCount;
  mfid_pkg::mfid_cmd_t cmd;
  int num_errors, n_checks;

  always #5 mclk = ~mclk;

  mfid_contact_model u_contacts (.mclk(mclk), .levelReq(levelReq), .contactIn(contactIn));

  mfid_decoder #(.COUNT_W(16)) u_dut (
    .mclk(mclk), .resetn(resetn), .contactIn(contactIn), .stopRequest(stopRequest),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .cmd(cmd), .eventCount(eventCount)
  );

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] got);
    n_checks++;
    if (got !== expv) begin
      $display("unexpected %s expected %h seen %h", what, expv, got);
      num_errors++;
    end
  endtask : chk

  task automatic give_up(input string what);
    $display("unexpected %s wait expected answer seen none", what);
    num_errors++;
    print_verdict();
  endtask : give_up

  task automatic axi_write(input logic [31:0] addr, input logic [31:0] data,
                           input logic [1:0] expResp);
    logic aHit, wHit, hit;
    logic [1:0] resp;
    int n;
    n = 0;
    @(posedge mclk);
    awaddr <= addr;
    wdata <= data;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge mclk);
      aHit = awvalid && (awready === 1'b1);
      wHit = wvalid && (wready === 1'b1);
      @(posedge mclk);
      if (aHit) awvalid <= 1'b0;
      if (wHit) wvalid <= 1'b0;
      n++;
      if (n > 50) give_up("write");
    end while ((awvalid && !aHit) || (wvalid && !wHit));
    bready <= 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      hit = (bvalid === 1'b1);
      resp = bresp;
      @(posedge mclk);
      n++;
      if (n > 50) give_up("bvalid");
    end while (!hit);
    bready <= 1'b0;
    chk("bresp", {30'h0, expResp}, {30'h0, resp});
  endtask : axi_write

  task automatic axi_read(input logic [31:0] addr, input logic [31:0] expData,
                          input logic [1:0] expResp);
    logic hit;
    logic [31:0] data;
    logic [1:0] resp;
    int n;
    n = 0;
    @(posedge mclk);
    araddr <= addr;
    arvalid <= 1'b1;
    do begin
      @(negedge mclk);
      hit = (arready === 1'b1);
      @(posedge mclk);
      n++;
      if (n > 50) give_up("arready");
    end while (!hit);
    arvalid <= 1'b0;
    rready <= 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      hit = (rvalid === 1'b1);
      data = rdata;
      resp = rresp;
      @(posedge mclk);
      n++;
      if (n > 50) give_up("rvalid");
    end while (!hit);
    rready <= 1'b0;
    chk("rdata", expData, data);
    chk("rresp", {30'h0, expResp}, {30'h0, resp});
  endtask : axi_read

  task automatic sel(input int i, input logic [7:0] code);
    axi_write(mfid_pkg::ADDR_SEL0 + 32'(4 * i), {24'h0, code}, mfid_pkg::RESP_OKAY);
  endtask : sel

  // Input path needs five edges plus one in the contact model
  task automatic set_lv(input logic [5:0] lv);
    @(posedge mclk);
    levelReq <= lv;
    repeat (8) @(posedge mclk);
  endtask : set_lv

  function automatic mfid_pkg::mfid_cmd_t exp_for(input logic [7:0] code);
    mfid_pkg::mfid_cmd_t c;
    c = '0;
    c.useSteppingSpeed = 1'b1;
    case (code)
      mfid_pkg::FN_HOLD: c.rampHold = 1'b1;
      mfid_pkg::FN_JOG_FWD: c.jogFwd = 1'b1;
      mfid_pkg::FN_JOG_REV: c.jogRev = 1'b1;
      mfid_pkg::FN_FAST_STOP: c.fastStop = 1'b1;
      mfid_pkg::FN_PID_OFF: c.pidDisable = 1'b1;
      mfid_pkg::FN_RAMP2: c.rampSet2 = 1'b1;
      mfid_pkg::FN_PID_ICLR: c.pidIntegralClear = 1'b1;
      mfid_pkg::FN_RUN_FWD: c.runFwd = 1'b1;
      mfid_pkg::FN_RUN_REV: c.runRev = 1'b1;
      mfid_pkg::FN_BASEBLOCK: c.baseblock = 1'b1;
      mfid_pkg::FN_RUN_SRC: c.runSourceAux = 1'b1;
      mfid_pkg::FN_REF_SRC: c.refSourceAux = 1'b1;
      mfid_pkg::FN_RIDE: c.rideThrough = 1'b1;
      mfid_pkg::FN_AUTO: c.autoProcess = 1'b1;
      mfid_pkg::FN_PULSE: c.pulseIn = 1'b0;
      default: c.pulseIn = 1'b0;
    endcase
    return c;
  endfunction : exp_for

  task automatic t_reset();
    logic [7:0] rst [6] = '{8'h80, 8'h81, 8'h03, 8'h04, 8'h05, 8'h0A};
    for (int i = 0; i < 6; i++) begin
      axi_read(mfid_pkg::ADDR_SEL0 + 32'(4 * i), {24'h0, rst[i]}, mfid_pkg::RESP_OKAY);
    end
    axi_read(mfid_pkg::ADDR_CFG, 32'h0, mfid_pkg::RESP_OKAY);
    axi_read(32'h0000_0040, 32'h0, mfid_pkg::RESP_SLVERR);
    axi_write(32'h0000_0040, 32'h0000_0012, mfid_pkg::RESP_SLVERR);
    set_lv(6'b000001);
    chk("cmd", 32'(exp_for(mfid_pkg::FN_RUN_FWD)), 32'(cmd));
    axi_read(mfid_pkg::ADDR_STATUS, 32'(exp_for(mfid_pkg::FN_RUN_FWD)), mfid_pkg::RESP_OKAY);
    set_lv(6'b000000);
    chk("cmd", 32'(exp_for(8'h00)), 32'(cmd));
  endtask : t_reset

  task automatic t_range();
    sel(1, 8'h02);
    sel(1, 8'h8A);
    axi_read(mfid_pkg::ADDR_SEL0 + 32'h4, 32'h81, mfid_pkg::RESP_OKAY);
    sel(1, mfid_pkg::FN_PULSE);
    axi_read(mfid_pkg::ADDR_SEL0 + 32'h4, 32'h89, mfid_pkg::RESP_OKAY);
    set_lv(6'b000010);
    chk("pulse on terminal two", 32'(exp_for(8'h00)), 32'(cmd));
    sel(5, mfid_pkg::FN_PULSE);
    set_lv(6'b100000);
    chk("pulse on terminal six", 32'h1, 32'(cmd.pulseIn));
    set_lv(6'b000000);
  endtask : t_range

  task automatic t_preset();
    sel(5, mfid_pkg::FN_STEP3);
    for (int v = 0; v < 16; v++) begin
      set_lv({v[3], v[2], v[1], v[0], 2'b00});
      chk("presetIndex", 32'(v), 32'(cmd.presetIndex));
      chk("useSteppingSpeed", 32'(v == 0), 32'(cmd.useSteppingSpeed));
    end
    sel(4, 8'h20);
    set_lv(6'b111100);
    chk("presetIndex", 32'hB, 32'(cmd.presetIndex));
    sel(4, mfid_pkg::FN_STEP2);
    sel(5, 8'h0A);
    set_lv(6'b000000);
  endtask : t_preset

  task automatic t_func();
    logic [7:0] codes [15] = '{8'h0A, 8'h12, 8'h13, 8'h15, 8'h19, 8'h1A, 8'h30, 8'h80,
                               8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h20};
    for (int i = 0; i < 15; i++) begin
      sel(1, codes[i]);
      set_lv(6'b000010);
      chk("cmd active", 32'(exp_for(codes[i])), 32'(cmd));
      set_lv(6'b000000);
      chk("cmd idle", 32'(exp_for(8'h00)), 32'(cmd));
    end
  endtask : t_func

  task automatic t_step();
    mfid_pkg::mfid_step_t e;
    sel(1, mfid_pkg::FN_UP);
    sel(2, mfid_pkg::FN_DOWN);
    for (int k = 0; k < 4; k++) begin
      set_lv({3'b000, k[1], k[0], 1'b0});
      e = (k == 1) ? mfid_pkg::STEP_ACCEL : (k == 2) ? mfid_pkg::STEP_DECEL : mfid_pkg::STEP_HOLD;
      chk("step", 32'(e), 32'(cmd.step));
    end
    sel(2, mfid_pkg::FN_STEP0);
    set_lv(6'b000000);
  endtask : t_step

  task automatic t_fault();
    int cnt;
    cnt = 0;
    sel(1, mfid_pkg::FN_FAULT_RST);
    @(posedge mclk);
    levelReq <= 6'b000010;
    repeat (30) begin
      @(negedge mclk);
      if (cmd.faultReset === 1'b1) cnt++;
    end
    chk("faultReset pulses", 32'h1, 32'(cnt));
    set_lv(6'b000000);
  endtask : t_fault

  task automatic t_counter();
    sel(1, mfid_pkg::FN_CNT_TRIG);
    sel(4, mfid_pkg::FN_CNT_CLR);
    repeat (3) begin
      set_lv(6'b000010);
      set_lv(6'b000000);
    end
    chk("eventCount", 32'h3, 32'(eventCount));
    set_lv(6'b010000);
    chk("eventCount", 32'h0, 32'(eventCount));
    set_lv(6'b010010);
    set_lv(6'b010000);
    chk("eventCount", 32'h0, 32'(eventCount));
    set_lv(6'b000000);
    set_lv(6'b000010);
    chk("eventCount", 32'h1, 32'(eventCount));
    axi_read(mfid_pkg::ADDR_COUNT, 32'h1, mfid_pkg::RESP_OKAY);
    sel(4, mfid_pkg::FN_STEP2);
    set_lv(6'b000000);
  endtask : t_counter

  task automatic t_source();
    logic [31:0] cfgs [4] = '{32'h0106, 32'h0106, 32'h0601, 32'h0601};
    sel(1, mfid_pkg::FN_REF_SRC);
    for (int k = 0; k < 4; k++) begin
      axi_write(mfid_pkg::ADDR_CFG, cfgs[k], mfid_pkg::RESP_OKAY);
      axi_read(mfid_pkg::ADDR_CFG, cfgs[k], mfid_pkg::RESP_OKAY);
      set_lv({4'b0000, k[0], 1'b0});
      chk("refSourceAux", 32'(k % 2), 32'(cmd.refSourceAux));
      chk("useSteppingSpeed", 32'(k == 0 || k == 3), 32'(cmd.useSteppingSpeed));
    end
    // Break-contact setting on terminal two: an open contact counts as active
    axi_write(mfid_pkg::ADDR_CFG, 32'h0002_0000, mfid_pkg::RESP_OKAY);
    set_lv(6'b000000);
    chk("refSourceAux open contact", 32'h1, 32'(cmd.refSourceAux));
    axi_read(mfid_pkg::ADDR_LEVELS, 32'h2, mfid_pkg::RESP_OKAY);
    axi_write(mfid_pkg::ADDR_CFG, 32'h0, mfid_pkg::RESP_OKAY);
    set_lv(6'b000000);
  endtask : t_source

  task automatic t_hold();
    sel(1, mfid_pkg::FN_HOLD);
    set_lv(6'b000010);
    chk("rampHold", 32'h1, 32'(cmd.rampHold));
    @(posedge mclk);
    stopRequest <= 1'b1;
    repeat (2) @(posedge mclk);
    stopRequest <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("rampHold after stop", 32'h0, 32'(cmd.rampHold));
    set_lv(6'b000000);
    set_lv(6'b000010);
    chk("rampHold", 32'h1, 32'(cmd.rampHold));
    set_lv(6'b000000);
  endtask : t_hold

  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    stopRequest = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 32'h0;
    wdata = 32'h0;
    araddr = 32'h0;
    wstrb = 4'h0;
    levelReq = 6'h00;
    num_errors = 0;
    n_checks = 0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_range();
    t_preset();
    t_func();
    t_step();
    t_fault();
    t_counter();
    t_source();
    t_hold();
    print_verdict();
  end
endmodule : tb_top
